// File: design/smirl_top.sv
// SMI routing block with AXI4-Lite register access
`default_nettype none
`include "smirl_map.svh"
// Function
// - Keyboard option bit 7 sets port bit 2 polarity; zero is active low.
// - Keyboard option bit 2 enables fast gate/reset port; other bits reserved.
// - Indices F1 through FF of keyboard range read as zero.
// - First enable register gates parallel, UARTs, floppy and watchdog sources.
// - Second enable register gates mouse, keyboard and infrared activity.
// - Second enable bit 4 routes keyboard port bit 2 into group interrupt.
// - Second enable bit 6 places group interrupt onto serial IRQ stream.
// - Second enable bit 7 drives group interrupt on pin; else pin floats.
// - First status bits mirror their sources; software writes cannot clear them.
// - Infrared status set by any receive transition; cleared by status read.
module smirl_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  input wire logic HOST_RST,
  // AXI4-Lite write address and data
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Interrupt sources
  input wire logic PARALLEL_IRQ,
  input wire logic UART_TWO_IRQ,
  input wire logic UART_ONE_IRQ,
  input wire logic FLOPPY_IRQ,
  input wire logic WATCHDOG_IRQ,
  input wire logic MOUSE_IRQ,
  input wire logic KEYBOARD_IRQ,
  input wire logic IR_RX_SEL,
  input wire logic KBC_PORT1_BIT2_OUT,
  // Group interrupt, keyboard port and event interrupt outputs
  output logic SYS_MGMT_IRQ_N,
  output logic SMI_PIN_OUT,
  output logic SMI_PIN_OE,
  output logic SERIAL_IRQ_SMI_N,
  output logic KBC_P12_PIN,
  output logic FAST_GATE_RESET_EN,
  output logic IRQ
);
  smirl_pkg::smirl_byte_t en_a_ff;
  smirl_pkg::smirl_byte_t en_b_ff;
  smirl_pkg::smirl_byte_t kbd_opt_ff;
  logic infrared_activity_flag_ff;
  logic ir_pulse;
  smirl_pkg::smirl_byte_t stat_a;
  smirl_pkg::smirl_byte_t stat_b;
  logic group_act;
  smirl_pkg::smirl_wr_t wst_ff;
  smirl_pkg::smirl_wr_t nxt_wst;
  logic aw_have_ff;
  logic w_have_ff;
  logic [11:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic wr_go;
  logic wr_hit;
  logic rd_go;
  logic rd_b_hit;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [2:0] src_now;
  logic [2:0] src_prev_ff;
  logic irq_st_wr;
  logic irq_msk_wr;
  logic irq_q;

  smirl_evt_if evif ();

  // ----------------------------------------------------------------
  // Source status
  // ----------------------------------------------------------------
  smirl_edge u_edge (
    .clk(CLK),
    .rst(RST),
    .line_in(IR_RX_SEL),
    .pulse(ir_pulse)
  );

  // Port bit 2 is normalised to active high before routing
  logic p12_active;
  assign p12_active = kbd_opt_ff[`SMIRL_K_POL] ? KBC_PORT1_BIT2_OUT : ~KBC_PORT1_BIT2_OUT;

  always_comb begin
    stat_a = `SMIRL_RST_BYTE;
    stat_a[1] = PARALLEL_IRQ;
    stat_a[2] = UART_TWO_IRQ;
    stat_a[3] = UART_ONE_IRQ;
    stat_a[4] = FLOPPY_IRQ;
    stat_a[7] = WATCHDOG_IRQ;
    stat_b = `SMIRL_RST_BYTE;
    stat_b[`SMIRL_B_MOUSE] = MOUSE_IRQ;
    stat_b[`SMIRL_B_KBD] = KEYBOARD_IRQ;
    stat_b[`SMIRL_B_IR] = infrared_activity_flag_ff;
    stat_b[`SMIRL_B_P12] = p12_active;
  end

  // Transition sets, read of second status clears; set wins
  always_ff @(posedge CLK) begin
    if (RST) begin
      infrared_activity_flag_ff <= 1'b0;
    end else if (ir_pulse) begin
      infrared_activity_flag_ff <= 1'b1;
    end else if (rd_go && rd_b_hit) begin
      infrared_activity_flag_ff <= 1'b0;
    end
  end

  // Enable masks also cover the polarity-corrected port bit
  assign group_act = |(stat_a & en_a_ff & `SMIRL_EN_A_MASK)
    | (|(stat_b[2:0] & en_b_ff[2:0]))
    | (stat_b[`SMIRL_B_P12] & en_b_ff[`SMIRL_B_P12]);

  // ----------------------------------------------------------------
  // Group interrupt and keyboard port outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      SYS_MGMT_IRQ_N <= 1'b1;
      SERIAL_IRQ_SMI_N <= 1'b1;
      SMI_PIN_OUT <= 1'b1;
      SMI_PIN_OE <= 1'b0;
    end else begin
      SYS_MGMT_IRQ_N <= ~group_act;
      SERIAL_IRQ_SMI_N <= ~(group_act & en_b_ff[`SMIRL_B_SERIRQ]);
      SMI_PIN_OUT <= ~group_act;
      SMI_PIN_OE <= en_b_ff[`SMIRL_B_PIN];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      KBC_P12_PIN <= 1'b0;
      FAST_GATE_RESET_EN <= 1'b0;
    end else begin
      KBC_P12_PIN <= p12_active ^ ~kbd_opt_ff[`SMIRL_K_POL];
      FAST_GATE_RESET_EN <= kbd_opt_ff[`SMIRL_K_P92];
    end
  end

  // ----------------------------------------------------------------
  // Event capture into the interrupt unit
  // ----------------------------------------------------------------
  assign src_now = {WATCHDOG_IRQ, FLOPPY_IRQ | UART_ONE_IRQ | UART_TWO_IRQ | PARALLEL_IRQ,
    ir_pulse};

  always_ff @(posedge CLK) begin
    if (RST) begin
      src_prev_ff <= 3'h0;
    end else begin
      src_prev_ff <= src_now;
    end
  end

  assign evif.evt = src_now & ~src_prev_ff;

  smirl_irq u_irq (
    .clk(CLK),
    .rst(RST),
    .ev(evif),
    .st_wr(irq_st_wr),
    .msk_wr(irq_msk_wr),
    .wdata(w_data_ff[2:0]),
    .irq_ff(irq_q)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_q;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign wr_go = (wst_ff == smirl_pkg::SMIRL_WR_IDLE) && aw_have_ff && w_have_ff;
  assign wr_hit = (aw_addr_ff[11:2] == {2'h0, `SMIRL_IDX_EN_A})
    || (aw_addr_ff[11:2] == {2'h0, `SMIRL_IDX_EN_B})
    || (aw_addr_ff[11:2] == {2'h0, `SMIRL_IDX_STAT_A})
    || (aw_addr_ff[11:2] == {2'h0, `SMIRL_IDX_STAT_B})
    || ((aw_addr_ff[11:2] >= {2'h0, `SMIRL_IDX_KBD_OPT})
      && (aw_addr_ff[11:2] <= {2'h0, `SMIRL_IDX_KBD_RSV_HI}))
    || (aw_addr_ff == `SMIRL_ADDR_INTST) || (aw_addr_ff == `SMIRL_ADDR_INTMSK)
    || (aw_addr_ff == `SMIRL_ADDR_SRC);
  assign irq_st_wr = wr_go && w_strb_ff[0] && (aw_addr_ff == `SMIRL_ADDR_INTST);
  assign irq_msk_wr = wr_go && w_strb_ff[0] && (aw_addr_ff == `SMIRL_ADDR_INTMSK);

  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_have_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
      S_AXI_AWREADY <= 1'b1;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_ff <= 1'b1;
      aw_addr_ff <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end else if (wr_go) begin
      aw_have_ff <= 1'b0;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      w_have_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      S_AXI_WREADY <= 1'b1;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_ff <= 1'b1;
      w_data_ff <= S_AXI_WDATA;
      w_strb_ff <= S_AXI_WSTRB;
      S_AXI_WREADY <= 1'b0;
    end else if (wr_go) begin
      w_have_ff <= 1'b0;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_WREADY <= 1'b1;
    end
  end

  always_comb begin
    nxt_wst = wst_ff;
    case (wst_ff)
      smirl_pkg::SMIRL_WR_IDLE: if (wr_go) nxt_wst = smirl_pkg::SMIRL_WR_RESP;
      smirl_pkg::SMIRL_WR_RESP: if (S_AXI_BREADY) nxt_wst = smirl_pkg::SMIRL_WR_IDLE;
      default: nxt_wst = smirl_pkg::SMIRL_WR_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      wst_ff <= smirl_pkg::SMIRL_WR_IDLE;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `SMIRL_RESP_OKAY;
    end else begin
      wst_ff <= nxt_wst;
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_hit ? `SMIRL_RESP_OKAY : `SMIRL_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Enables survive the host reset drive; only supply power-on clears them
  always_ff @(posedge CLK) begin
    if (RST) begin
      en_a_ff <= `SMIRL_RST_BYTE;
      en_b_ff <= `SMIRL_RST_BYTE;
    end else if (wr_go && w_strb_ff[0]) begin
      if (aw_addr_ff[11:2] == {2'h0, `SMIRL_IDX_EN_A}) begin
        en_a_ff <= w_data_ff[7:0] & `SMIRL_EN_A_MASK;
      end
      if (aw_addr_ff[11:2] == {2'h0, `SMIRL_IDX_EN_B}) begin
        en_b_ff <= w_data_ff[7:0] & `SMIRL_EN_B_MASK;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || HOST_RST) begin
      kbd_opt_ff <= `SMIRL_RST_BYTE;
    end else if (wr_go && w_strb_ff[0]
        && aw_addr_ff[11:2] == {2'h0, `SMIRL_IDX_KBD_OPT}) begin
      kbd_opt_ff <= w_data_ff[7:0] & `SMIRL_KBD_MASK;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_b_hit = S_AXI_ARADDR[11:2] == {2'h0, `SMIRL_IDX_STAT_B};

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (S_AXI_ARADDR == `SMIRL_ADDR_INTST) begin
      rd_val[2:0] = evif.status;
    end else if (S_AXI_ARADDR == `SMIRL_ADDR_INTMSK) begin
      rd_val[2:0] = evif.mask;
    end else if (S_AXI_ARADDR == `SMIRL_ADDR_SRC) begin
      rd_val[0] = group_act;
    end else begin
      case (S_AXI_ARADDR[11:2])
        {2'h0, `SMIRL_IDX_EN_A}: rd_val[7:0] = en_a_ff;
        {2'h0, `SMIRL_IDX_EN_B}: rd_val[7:0] = en_b_ff;
        {2'h0, `SMIRL_IDX_STAT_A}: rd_val[7:0] = stat_a;
        {2'h0, `SMIRL_IDX_STAT_B}: rd_val[7:0] = stat_b;
        {2'h0, `SMIRL_IDX_KBD_OPT}: rd_val[7:0] = kbd_opt_ff;
        default: rd_hit = (S_AXI_ARADDR[11:2] >= {2'h0, `SMIRL_IDX_KBD_RSV_LO})
          && (S_AXI_ARADDR[11:2] <= {2'h0, `SMIRL_IDX_KBD_RSV_HI});
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `SMIRL_RESP_OKAY;
    end else if (rd_go) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_val;
      S_AXI_RRESP <= rd_hit ? `SMIRL_RESP_OKAY : `SMIRL_RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_group_low: assert property (@(posedge CLK) disable iff (RST)
    group_act |=> !SYS_MGMT_IRQ_N)
    else $error("group interrupt not low while enabled source set");
  a_pin_float: assert property (@(posedge CLK) disable iff (RST)
    !en_b_ff[`SMIRL_B_PIN] |=> !SMI_PIN_OE)
    else $error("pin driven while routing disabled");
  a_serial_gate: assert property (@(posedge CLK) disable iff (RST)
    !en_b_ff[`SMIRL_B_SERIRQ] |=> SERIAL_IRQ_SMI_N)
    else $error("serial stream shows group while disabled");
  a_ir_sets: assert property (@(posedge CLK) disable iff (RST)
    ir_pulse |=> infrared_activity_flag_ff)
    else $error("infrared transition lost");
  a_ir_clears: assert property (@(posedge CLK) disable iff (RST)
    rd_go && rd_b_hit && !ir_pulse |=> !infrared_activity_flag_ff)
    else $error("infrared flag survived status read");
  a_src_blocked: assert property (@(posedge CLK) disable iff (RST)
    (en_a_ff == 8'h00) && (en_b_ff[4:0] == 5'h00) |=> SYS_MGMT_IRQ_N)
    else $error("disabled sources reach group interrupt");
  a_p12_route: assert property (@(posedge CLK) disable iff (RST)
    en_b_ff[`SMIRL_B_P12] && p12_active |=> !SYS_MGMT_IRQ_N)
    else $error("port bit not routed");
  a_port92_en: assert property (@(posedge CLK) disable iff (RST || HOST_RST)
    1'b1 |=> FAST_GATE_RESET_EN == $past(kbd_opt_ff[`SMIRL_K_P92]))
    else $error("fast gate enable mismatch");
  a_rsv_zero: assert property (@(posedge CLK) disable iff (RST)
    rd_go && S_AXI_ARADDR[11:2] >= {2'h0, `SMIRL_IDX_KBD_RSV_LO} && S_AXI_ARADDR[11:10] == 2'h0
    |=> S_AXI_RDATA == 32'h0000_0000)
    else $error("reserved index not zero");
  a_pol_low: assert property (@(posedge CLK) disable iff (RST)
    !kbd_opt_ff[`SMIRL_K_POL] && !KBC_PORT1_BIT2_OUT |-> p12_active)
    else $error("active-low polarity wrong");
  a_stat_mirror: assert property (@(posedge CLK) disable iff (RST)
    stat_a[4:1] == {FLOPPY_IRQ, UART_ONE_IRQ, UART_TWO_IRQ, PARALLEL_IRQ})
    else $error("status does not mirror sources");
endmodule : smirl_top
`default_nettype wire

// File: design/smirl_map.svh
// Register offsets, field positions and reset values of the SMI routing block
`ifndef SMIRL_MAP_SVH
`define SMIRL_MAP_SVH

`define SMIRL_IDX_EN_A 8'hB4
`define SMIRL_IDX_EN_B 8'hB5
`define SMIRL_IDX_STAT_A 8'hB6
`define SMIRL_IDX_STAT_B 8'hB7
`define SMIRL_IDX_KBD_OPT 8'hF0
`define SMIRL_IDX_KBD_RSV_LO 8'hF1
`define SMIRL_IDX_KBD_RSV_HI 8'hFF
`define SMIRL_ADDR_INTST 12'h400
`define SMIRL_ADDR_INTMSK 12'h404
`define SMIRL_ADDR_SRC 12'h408

`define SMIRL_EN_A_MASK 8'h9E
`define SMIRL_EN_B_MASK 8'hD7
`define SMIRL_KBD_MASK 8'h84
`define SMIRL_RST_BYTE 8'h00

`define SMIRL_B_MOUSE 0
`define SMIRL_B_KBD 1
`define SMIRL_B_IR 2
`define SMIRL_B_P12 4
`define SMIRL_B_SERIRQ 6
`define SMIRL_B_PIN 7
`define SMIRL_K_POL 7
`define SMIRL_K_P92 2

`define SMIRL_RESP_OKAY 2'h0
`define SMIRL_RESP_SLVERR 2'h2

`endif

// File: design/smirl_pkg.sv
// Types shared by the SMI routing block
`default_nettype none
package smirl_pkg;
  typedef enum logic [2:0] {
    SMIRL_WR_IDLE = 3'h1,
    SMIRL_WR_RESP = 3'h2,
    SMIRL_WR_WAIT = 3'h4
  } smirl_wr_t;
  typedef logic [7:0] smirl_byte_t;
endpackage : smirl_pkg
`default_nettype wire

// File: design/smirl_evt_if.sv
// Event bundle between the routing core and the interrupt register unit
`default_nettype none
interface smirl_evt_if;
  logic [2:0] evt;
  logic [2:0] status;
  logic [2:0] mask;
  modport src(output evt, input status, input mask);
  modport dst(input evt, output status, output mask);
endinterface : smirl_evt_if
`default_nettype wire

// File: design/smirl_irq.sv
// Sticky event status, mask and level interrupt output
`default_nettype none
`include "smirl_map.svh"
module smirl_irq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Events and software access
  smirl_evt_if.dst ev,
  input wire logic st_wr,
  input wire logic msk_wr,
  input wire logic [2:0] wdata,
  // Interrupt level
  output logic irq_ff
);
  logic [2:0] status_ff;
  logic [2:0] mask_ff;

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      status_ff <= 3'h0;
    end else begin
      status_ff <= (status_ff & ~(st_wr ? wdata : 3'h0)) | ev.evt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_ff <= 3'h0;
    end else if (msk_wr) begin
      mask_ff <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |((status_ff & ~(st_wr ? wdata : 3'h0) | ev.evt) & mask_ff);
    end
  end

  assign ev.status = status_ff;
  assign ev.mask = mask_ff;

  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    irq_ff == |($past(status_ff) & $past(mask_ff)) || $past(st_wr) || $past(msk_wr)
    || |$past(ev.evt))
    else $error("interrupt level disagrees with status and mask");
endmodule : smirl_irq
`default_nettype wire

// File: design/smirl_edge.sv
// Transition detector for the selected infrared receive line
`default_nettype none
module smirl_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Line in, one-cycle transition pulse out
  input wire logic line_in,
  output logic pulse
);
  logic prev_ff;
  logic seen_ff;

  // First sample after reset only primes the history
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else begin
      prev_ff <= line_in;
      seen_ff <= 1'b1;
    end
  end

  assign pulse = seen_ff && (line_in != prev_ff);
endmodule : smirl_edge
`default_nettype wire

// File: verification/smirl_host_model.sv
// Host-side model of the system-management interrupt input pin
`default_nettype none
module smirl_host_model (
  // Clock
  input wire logic clk,
  // Dedicated pin as driven by the device
  input wire logic pin_out,
  input wire logic pin_oe,
  // Level seen by the host
  output logic pin_level,
  output logic seen_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // Board pull-up wins whenever the device floats the pin
  assign pin_level = pin_oe ? pin_out : 1'b1;
  always_ff @(posedge clk) begin
    seen_ff <= ~pin_level;
  end
endmodule // smirl_host_model
`default_nettype wire

// File: verification/smirl_tb_top.sv
// Self-checking bench of the SMI routing block
`default_nettype none
`include "smirl_map.svh"
module smirl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, host_rst, awvalid, wvalid, bready, arvalid, rready, ir, p12, m_ir;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rd, v;
  logic [7:0] srca, srcb, m_ena, m_enb, m_kbd;
  logic [1:0] rs;
  logic awready, wready, bvalid, arready, rvalid, grp_n, pin_out, pin_oe, ser_n;
  logic p12_pin, fast_en, irq, pin_level, seen;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int mismatches, n_checks, seed;

  smirl_top dut (
    .CLK(clk), .RST(rst), .HOST_RST(host_rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .PARALLEL_IRQ(srca[1]), .UART_TWO_IRQ(srca[2]),
    .UART_ONE_IRQ(srca[3]), .FLOPPY_IRQ(srca[4]), .WATCHDOG_IRQ(srca[7]),
    .MOUSE_IRQ(srcb[0]), .KEYBOARD_IRQ(srcb[1]), .IR_RX_SEL(ir),
    .KBC_PORT1_BIT2_OUT(p12), .SYS_MGMT_IRQ_N(grp_n), .SMI_PIN_OUT(pin_out),
    .SMI_PIN_OE(pin_oe), .SERIAL_IRQ_SMI_N(ser_n), .KBC_P12_PIN(p12_pin),
    .FAST_GATE_RESET_EN(fast_en), .IRQ(irq)
  );
  smirl_host_model host (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_level(pin_level), .seen_ff(seen));

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic results();
    if (mismatches == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
    end
  endtask

  // ----------------------------------------
  // AXI4-Lite master
  // ----------------------------------------
  // Handshakes are judged at the falling edge, where ready holds its pre-edge value
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(negedge clk);
      aw_hs = awvalid & awready;
      w_hs = wvalid & wready;
      b_hs = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) begin
        bready <= 1'b0;
        return;
      end
    end
    mismatches++;
    results();
  endtask
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 100; k++) begin
      @(negedge clk);
      ar_hs = arvalid & arready;
      r_hs = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) begin
        rready <= 1'b0;
        return;
      end
    end
    mismatches++;
    results();
  endtask
  task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
    axi_read(a, rd, rs);
    chk(n, rd, e);
    chk("rresp", 32'(rs), 32'(`SMIRL_RESP_OKAY));
  endtask

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic logic p12_act();
    return m_kbd[7] ? p12 : ~p12;
  endfunction
  function automatic logic m_grp();
    return (|(srca & m_ena)) | (srcb[0] & m_enb[0]) | (srcb[1] & m_enb[1])
      | (m_ir & m_enb[2]) | (p12_act() & m_enb[4]);
  endfunction
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic check_outs();
    logic g;
    g = m_grp();
    chk("group_n", 32'(grp_n), {31'h0, ~g});
    chk("serial_n", 32'(ser_n), {31'h0, ~(g & m_enb[6])});
    chk("pin_oe", 32'(pin_oe), 32'(m_enb[7]));
    chk("pin_level", 32'(pin_level), {31'h0, m_enb[7] ? ~g : 1'b1});
    chk("host_seen", 32'(seen), {31'h0, m_enb[7] & g});
    chk("p12_pin", 32'(p12_pin), 32'(p12));
    chk("fast_gate", 32'(fast_en), 32'(m_kbd[2]));
  endtask

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst, host_rst, awvalid, wvalid, bready, arvalid, rready, ir, p12, m_ir} = 10'h200;
    {awaddr, araddr, wdata, srca, srcb} = '0;
    {m_ena, m_enb, m_kbd} = '0;
    mismatches = 0;
    n_checks = 0;
    seed = 32'hBD2012DD;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle();
    check_outs();
    rchk("en_a_rst", 12'h2D0, 32'h0);
    rchk("en_b_rst", 12'h2D4, 32'h0);
    rchk("kbd_rst", 12'h3C0, 32'h0);
    for (int a = 12'h3C4; a <= 12'h3FC; a += 4) begin
      axi_write(12'(a), 32'hFF, rs);
      rchk("kbd_rsv", 12'(a), 32'h0);
    end
    axi_write(12'h100, 32'hFF, rs);
    chk("bresp_unmapped", 32'(rs), 32'(`SMIRL_RESP_SLVERR));
    axi_read(12'h100, rd, rs);
    chk("rresp_unmapped", 32'(rs), 32'(`SMIRL_RESP_SLVERR));
    for (int i = 0; i < 40; i++) begin
      v = $random(seed);
      axi_write(12'h2D0, v, rs);
      m_ena = v[7:0] & `SMIRL_EN_A_MASK;
      axi_write(12'h2D4, {v[31:8], v[15:8]}, rs);
      m_enb = v[15:8] & `SMIRL_EN_B_MASK;
      axi_write(12'h3C0, {24'h0, v[23:16]}, rs);
      m_kbd = v[23:16] & `SMIRL_KBD_MASK;
      v = $random(seed);
      @(posedge clk);
      srca <= v[7:0] & `SMIRL_EN_A_MASK;
      srcb <= {6'h0, v[9:8]};
      p12 <= v[10];
      if (v[11] != ir) m_ir = 1'b1;
      ir <= v[11];
      settle();
      check_outs();
      rchk("en_a", 12'h2D0, 32'(m_ena));
      rchk("en_b", 12'h2D4, 32'(m_enb));
      rchk("kbd_opt", 12'h3C0, 32'(m_kbd));
      axi_write(12'h2D8, 32'h0, rs);
      rchk("stat_a", 12'h2D8, 32'(srca));
      rchk("group_reg", 12'h408, 32'(m_grp()));
      rchk("stat_b", 12'h2DC, {27'h0, p12_act(), 1'b0, m_ir, srcb[1:0]});
      m_ir = 1'b0;
      rchk("stat_b_clr", 12'h2DC, {27'h0, p12_act(), 1'b0, m_ir, srcb[1:0]});
      settle();
      check_outs();
    end
    @(posedge clk);
    {srca, srcb} <= '0;
    settle();
    axi_write(12'h404, 32'h0, rs);
    axi_write(12'h400, 32'h7, rs);
    rchk("int_clr", 12'h400, 32'h0);
    @(posedge clk);
    srca <= 8'h80;
    settle();
    chk("irq_masked", 32'(irq), 32'h0);
    axi_write(12'h404, 32'h4, rs);
    settle();
    chk("irq_set", 32'(irq), 32'h1);
    axi_write(12'h400, 32'h4, rs);
    settle();
    chk("irq_cleared", 32'(irq), 32'h0);
    @(posedge clk);
    srca <= 8'h82;
    ir <= ~ir;
    m_ir = 1'b1;
    settle();
    rchk("int_events", 12'h400, 32'h3);
    axi_write(12'h3C0, 32'h84, rs);
    settle();
    chk("fast_gate_on", 32'(fast_en), 32'h1);
    @(posedge clk);
    host_rst <= 1'b1;
    @(posedge clk);
    host_rst <= 1'b0;
    settle();
    chk("fast_gate_host_rst", 32'(fast_en), 32'h0);
    rchk("kbd_host_rst", 12'h3C0, 32'h0);
    rchk("en_a_kept", 12'h2D0, 32'(m_ena));
    results();
  end
endmodule // smirl_tb_top
`default_nettype wire
